/* design/tar_pkg.sv */
// How it works
// RQ1 - high limit upper byte at 0x22
// RQ2 - high limit resets to 0x7FFF, alarm off
// RQ3 - high limit lower byte 0x23, resets 0xFF
// RQ4 - low limit upper byte at 0x24
// RQ5 - low limit resets to 0x8000, alarm off
// RQ6 - low limit lower byte 0x25, resets 0x00
// RQ7 - low crossing select 0..3 means 1..4 crossings
// RQ8 - rise slope 0x26, N times 5 mdeg/sample
// RQ9 - signed 16-bit limit comparisons
package tar_pkg;
    localparam logic [7:0] TAR_HIGH_UPPER_OFFSET = 8'h22;
    localparam logic [7:0] TAR_HIGH_LOWER_OFFSET = 8'h23;
    localparam logic [7:0] TAR_LOW_UPPER_OFFSET = 8'h24;
    localparam logic [7:0] TAR_LOW_LOWER_OFFSET = 8'h25;
    localparam logic [7:0] TAR_RISE_SLOPE_OFFSET = 8'h26;
    localparam logic [7:0] TAR_HIGH_UPPER_RESET = 8'h7f;
    localparam logic [7:0] TAR_HIGH_LOWER_RESET = 8'hff;
    localparam logic [7:0] TAR_LOW_UPPER_RESET = 8'h80;
    localparam logic [7:0] TAR_LOW_LOWER_RESET = 8'h00;
    localparam logic [7:0] TAR_RISE_SLOPE_RESET = 8'h00;
    localparam logic [15:0] TAR_HIGH_VALUE_RESET = 16'h7fff;
    localparam logic [15:0] TAR_LOW_VALUE_RESET = 16'h8000;
    localparam logic [7:0] TAR_UNMAPPED_DATA = 8'h00;
    localparam logic [10:0] TAR_SLOPE_STEP_MDEG = 11'h005;
    localparam logic [2:0] TAR_MAX_CROSSINGS = 3'h4;
    localparam logic [2:0] TAR_COUNT_RESET = 3'h0;

    typedef struct packed {
        logic [7:0] high_upper;
        logic [7:0] high_lower;
        logic [7:0] low_upper;
        logic [7:0] low_lower;
        logic [7:0] rise_slope;
        logic [15:0] high_value;
        logic [15:0] low_value;
        logic [10:0] slope_mdeg;
        logic [7:0] rdata;
        logic rvalid;
        logic high_flag;
        logic low_valid;
        logic low_below;
    } tar_regs_type;

    typedef struct packed {
        logic [2:0] count;
        logic flag;
    } tar_count_type;
endpackage : tar_pkg

/* design/tar_low_counter.sv */
`timescale 1ns/1ps
module tar_low_counter
    import tar_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sample_valid,
    input wire logic below,
    input wire logic [1:0] count_select,
    input wire logic flag_clear,
    output logic flag
);
    tar_count_type state;
    tar_count_type next_state;
    logic [2:0] needed;

    always_comb begin
        next_state = state;
        // select 0..3 asks for 1..4 consecutive crossings
        needed = {1'b0, count_select} + 3'h1; // RQ7
        if (flag_clear) begin
            next_state.flag = 1'b0;
        end
        if (sample_valid) begin
            if (below) begin
                // saturate so a long cold spell cannot wrap the count
                if (state.count != TAR_MAX_CROSSINGS) begin
                    next_state.count = state.count + 3'h1;
                end
                // set beats a clear arriving in the same cycle
                if (next_state.count >= needed) begin
                    next_state.flag = 1'b1; // RQ7
                end
            end else begin
                next_state.count = TAR_COUNT_RESET;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= '{count: TAR_COUNT_RESET, flag: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign flag = state.flag;

    AST_LOW_COUNT_REACHED: assert property (@(posedge clk) disable iff (!resetn) // RQ7
        $rose(flag) |-> state.count >= {1'b0, $past(count_select)} + 3'h1)
        else $error("low flag rose before enough crossings");

    AST_LOW_COUNT_SETS: assert property (@(posedge clk) disable iff (!resetn) // RQ7
        sample_valid && below && (state.count >= {1'b0, count_select}) |=> flag)
        else $error("low flag missing after enough crossings");
endmodule : tar_low_counter

/* design/tar_threshold_regs.sv */
`timescale 1ns/1ps
module tar_threshold_regs
    import tar_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic sample_valid,
    input wire logic [15:0] temp_sample,
    input wire logic [1:0] low_crossing_count_select,
    input wire logic high_flag_clear,
    input wire logic low_flag_clear,
    output logic [15:0] high_limit_value,
    output logic [15:0] low_limit_value,
    output logic [7:0] rise_slope_limit,
    output logic [10:0] rise_slope_mdeg,
    output logic high_limit_flag,
    output logic low_limit_flag
);
    tar_regs_type state;
    tar_regs_type next_state;

    always_comb begin
        next_state = state;
        next_state.rvalid = 1'b0;
        next_state.low_valid = 1'b0;
        next_state.low_below = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                TAR_HIGH_UPPER_OFFSET: begin
                    next_state.high_upper = reg_wdata; // RQ1
                end
                TAR_HIGH_LOWER_OFFSET: begin
                    next_state.high_lower = reg_wdata; // RQ3
                end
                TAR_LOW_UPPER_OFFSET: begin
                    next_state.low_upper = reg_wdata; // RQ4
                end
                TAR_LOW_LOWER_OFFSET: begin
                    next_state.low_lower = reg_wdata; // RQ6
                end
                TAR_RISE_SLOPE_OFFSET: begin
                    next_state.rise_slope = reg_wdata; // RQ8
                end
                default: begin
                    // writes outside the slice are dropped silently
                end
            endcase
        end
        // the two bytes are written separately, so the limit is briefly half old
        next_state.high_value = {next_state.high_upper, next_state.high_lower}; // RQ1
        next_state.low_value = {next_state.low_upper, next_state.low_lower}; // RQ4
        next_state.slope_mdeg = 11'(next_state.rise_slope) * TAR_SLOPE_STEP_MDEG; // RQ8
        if (reg_rd) begin
            next_state.rvalid = 1'b1;
            case (reg_addr)
                TAR_HIGH_UPPER_OFFSET: begin
                    next_state.rdata = state.high_upper;
                end
                TAR_HIGH_LOWER_OFFSET: begin
                    next_state.rdata = state.high_lower;
                end
                TAR_LOW_UPPER_OFFSET: begin
                    next_state.rdata = state.low_upper;
                end
                TAR_LOW_LOWER_OFFSET: begin
                    next_state.rdata = state.low_lower;
                end
                TAR_RISE_SLOPE_OFFSET: begin
                    next_state.rdata = state.rise_slope;
                end
                default: begin
                    next_state.rdata = TAR_UNMAPPED_DATA;
                end
            endcase
        end
        if (high_flag_clear) begin
            next_state.high_flag = 1'b0;
        end
        if (sample_valid) begin
            // signed compare keeps 0x7fff and 0x8000 out of reach
            if ($signed(temp_sample) > $signed(state.high_value)) begin
                next_state.high_flag = 1'b1; // RQ9
            end
            next_state.low_valid = 1'b1;
            next_state.low_below = $signed(temp_sample) < $signed(state.low_value); // RQ9
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state.high_upper <= TAR_HIGH_UPPER_RESET; // RQ2
            state.high_lower <= TAR_HIGH_LOWER_RESET; // RQ3
            state.low_upper <= TAR_LOW_UPPER_RESET; // RQ5
            state.low_lower <= TAR_LOW_LOWER_RESET; // RQ6
            state.rise_slope <= TAR_RISE_SLOPE_RESET;
            state.high_value <= TAR_HIGH_VALUE_RESET; // RQ2
            state.low_value <= TAR_LOW_VALUE_RESET; // RQ5
            state.slope_mdeg <= '0;
            state.rdata <= '0;
            state.rvalid <= 1'b0;
            state.high_flag <= 1'b0;
            state.low_valid <= 1'b0;
            state.low_below <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    tar_low_counter u_low_counter (
        .clk(clk),
        .resetn(resetn),
        .sample_valid(state.low_valid),
        .below(state.low_below),
        .count_select(low_crossing_count_select),
        .flag_clear(low_flag_clear),
        .flag(low_limit_flag)
    );

    assign reg_rdata = state.rdata;
    assign reg_rdata_valid = state.rvalid;
    assign high_limit_value = state.high_value;
    assign low_limit_value = state.low_value;
    assign rise_slope_limit = state.rise_slope;
    assign rise_slope_mdeg = state.slope_mdeg;
    assign high_limit_flag = state.high_flag;

    sequence read_of(logic [7:0] addr);
        reg_rd && !reg_wr && reg_addr == addr;
    endsequence

    AST_HIGH_RESET: assert property (@(posedge clk) disable iff (!resetn) // RQ2
        $rose(resetn) |-> high_limit_value == TAR_HIGH_VALUE_RESET && !high_limit_flag)
        else $error("high limit not at reset value");

    AST_LOW_RESET: assert property (@(posedge clk) disable iff (!resetn) // RQ5
        $rose(resetn) |-> low_limit_value == TAR_LOW_VALUE_RESET && !low_limit_flag)
        else $error("low limit not at reset value");

    AST_HIGH_UPPER_WRITE: assert property (@(posedge clk) disable iff (!resetn) // RQ1
        reg_wr && reg_addr == TAR_HIGH_UPPER_OFFSET
        |=> high_limit_value[15:8] == $past(reg_wdata))
        else $error("high upper byte write lost");

    AST_HIGH_LOWER_WRITE: assert property (@(posedge clk) disable iff (!resetn) // RQ3
        reg_wr && reg_addr == TAR_HIGH_LOWER_OFFSET
        |=> high_limit_value[7:0] == $past(reg_wdata) && $stable(high_limit_value[15:8]))
        else $error("high lower byte write wrong");

    AST_LOW_UPPER_WRITE: assert property (@(posedge clk) disable iff (!resetn) // RQ4
        reg_wr && reg_addr == TAR_LOW_UPPER_OFFSET
        |=> low_limit_value[15:8] == $past(reg_wdata) && $stable(low_limit_value[7:0]))
        else $error("low upper byte write wrong");

    AST_LOW_LOWER_WRITE: assert property (@(posedge clk) disable iff (!resetn) // RQ6
        reg_wr && reg_addr == TAR_LOW_LOWER_OFFSET
        |=> low_limit_value[7:0] == $past(reg_wdata))
        else $error("low lower byte write lost");

    AST_SLOPE_SCALE: assert property (@(posedge clk) disable iff (!resetn) // RQ8
        rise_slope_mdeg == 11'(rise_slope_limit) * TAR_SLOPE_STEP_MDEG)
        else $error("slope scale wrong");

    AST_HIGH_SIGNED: assert property (@(posedge clk) disable iff (!resetn) // RQ9
        sample_valid && $signed(temp_sample) > $signed(high_limit_value) |=> high_limit_flag)
        else $error("high crossing missed");

    // the below bit lags one cycle, so the limit must have stood at minimum then too
    AST_LOW_NEVER_AT_MIN: assert property (@(posedge clk) disable iff (!resetn) // RQ9
        low_limit_value == TAR_LOW_VALUE_RESET && $past(low_limit_value) == TAR_LOW_VALUE_RESET
        && !low_limit_flag |=> !low_limit_flag)
        else $error("low flag set at minimum limit");

    AST_READ_HIGH_UPPER: assert property (@(posedge clk) disable iff (!resetn) // RQ1
        read_of(TAR_HIGH_UPPER_OFFSET) |=> reg_rdata_valid
        && reg_rdata == $past(high_limit_value[15:8]))
        else $error("high upper read back wrong");

    AST_READ_SLOPE: assert property (@(posedge clk) disable iff (!resetn) // RQ8
        read_of(TAR_RISE_SLOPE_OFFSET) |=> reg_rdata_valid
        && reg_rdata == $past(rise_slope_limit))
        else $error("slope read back wrong");

    AST_READ_HIGH_LOWER: assert property (@(posedge clk) disable iff (!resetn) // RQ3
        read_of(TAR_HIGH_LOWER_OFFSET) |=> reg_rdata_valid
        && reg_rdata == $past(high_limit_value[7:0]))
        else $error("high lower read back wrong");

    AST_READ_LOW_UPPER: assert property (@(posedge clk) disable iff (!resetn) // RQ4
        read_of(TAR_LOW_UPPER_OFFSET) |=> reg_rdata_valid
        && reg_rdata == $past(low_limit_value[15:8]))
        else $error("low upper read back wrong");

    AST_READ_LOW_LOWER: assert property (@(posedge clk) disable iff (!resetn) // RQ6
        read_of(TAR_LOW_LOWER_OFFSET) |=> reg_rdata_valid
        && reg_rdata == $past(low_limit_value[7:0]))
        else $error("low lower read back wrong");

    AST_VALID_PULSE: assert property (@(posedge clk) disable iff (!resetn) // RQ1
        !reg_rd |=> !reg_rdata_valid)
        else $error("read valid without a read");

    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!resetn) // RQ1
        reg_rd && (reg_addr < TAR_HIGH_UPPER_OFFSET || reg_addr > TAR_RISE_SLOPE_OFFSET)
        |=> reg_rdata_valid && reg_rdata == TAR_UNMAPPED_DATA)
        else $error("unmapped read not zero");

    AST_READ_DURING_WRITE: assert property (@(posedge clk) disable iff (!resetn) // RQ3
        reg_rd && reg_wr && reg_addr == TAR_HIGH_LOWER_OFFSET
        |=> reg_rdata_valid && reg_rdata == $past(high_limit_value[7:0]))
        else $error("read during write not old value");

    AST_SLOPE_WRITE: assert property (@(posedge clk) disable iff (!resetn) // RQ8
        reg_wr && reg_addr == TAR_RISE_SLOPE_OFFSET |=> rise_slope_limit == $past(reg_wdata)
        && rise_slope_mdeg == 11'($past(reg_wdata)) * TAR_SLOPE_STEP_MDEG)
        else $error("slope write lost");

    AST_HIGH_STICKY: assert property (@(posedge clk) disable iff (!resetn) // RQ9
        high_limit_flag && !high_flag_clear |=> high_limit_flag)
        else $error("high flag dropped without clear");

    AST_SLOPE_RESET: assert property (@(posedge clk) disable iff (!resetn) // RQ8
        $rose(resetn) |-> rise_slope_limit == TAR_RISE_SLOPE_RESET && rise_slope_mdeg == '0
        && !reg_rdata_valid)
        else $error("slope not at reset value");
endmodule : tar_threshold_regs

/* dv/tar_host_model.sv */
`timescale 1ns/1ps
module tar_host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // one strobe per access; data inverted after so a stale value never matches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
    endtask : rd
    // read and write in one cycle; the read must return the old byte
    task automatic rdwr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
    endtask : rdwr
endmodule : tar_host_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import tar_pkg::*;
    logic clk, resetn, sample_valid, high_flag_clear, low_flag_clear;
    logic reg_wr, reg_rd, reg_rdata_valid, high_flag, low_flag;
    logic [15:0] temp_sample, high_value, low_value;
    logic [1:0] sel;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, slope, d;
    logic [10:0] mdeg;
    logic [7:0] exp_reg [5];
    int n_errors, checks, cycles, seed;

    tar_host_model i_tar_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    tar_threshold_regs i_tar_threshold_regs (.clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .sample_valid(sample_valid), .temp_sample(temp_sample),
        .low_crossing_count_select(sel), .high_flag_clear(high_flag_clear),
        .low_flag_clear(low_flag_clear), .high_limit_value(high_value),
        .low_limit_value(low_value), .rise_slope_limit(slope), .rise_slope_mdeg(mdeg),
        .high_limit_flag(high_flag), .low_limit_flag(low_flag));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [10:0] mdeg_of(input logic [7:0] n);
        return 11'(n) * 11'h005;
    endfunction : mdeg_of

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic regs_check();
        for (int k = 0; k < 5; k++) begin
            i_tar_host_model.rd(8'h22 + 8'(k));
            check(16'(reg_rdata_valid), 16'h0001);
            check(16'(reg_rdata), 16'(exp_reg[k]));
        end
        check(high_value, {exp_reg[0], exp_reg[1]});
        check(low_value, {exp_reg[2], exp_reg[3]});
        check(16'(slope), 16'(exp_reg[4]));
        check(16'(mdeg), 16'(mdeg_of(exp_reg[4])));
    endtask : regs_check

    task automatic sample(input logic [15:0] t);
        @(negedge clk);
        sample_valid = 1'b1;
        temp_sample = t;
        @(negedge clk);
        sample_valid = 1'b0;
        temp_sample = ~t;
    endtask : sample

    task automatic clear_flags();
        @(negedge clk);
        high_flag_clear = 1'b1;
        low_flag_clear = 1'b1;
        @(negedge clk);
        high_flag_clear = 1'b0;
        low_flag_clear = 1'b0;
        check(16'({high_flag, low_flag}), 16'h0000);
    endtask : clear_flags

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        seed = 32861;
        resetn = 1'b0;
        sample_valid = 1'b0;
        temp_sample = 16'h0000;
        sel = 2'h0;
        high_flag_clear = 1'b0;
        low_flag_clear = 1'b0;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        exp_reg = '{8'h7f, 8'hff, 8'h80, 8'h00, 8'h00};
        regs_check();
        check(high_value, TAR_HIGH_VALUE_RESET);
        check(low_value, TAR_LOW_VALUE_RESET);
        sample(16'h7fff);
        sample(16'h8000);
        repeat (3) @(negedge clk);
        check(16'({high_flag, low_flag}), 16'h0000);
        for (int k = 0; k < 5; k++) begin
            d = 8'($random(seed));
            i_tar_host_model.wr(8'h22 + 8'(k), d);
            exp_reg[k] = d;
        end
        regs_check();
        i_tar_host_model.wr(8'h21, 8'h5a);
        i_tar_host_model.rd(8'h21);
        check(16'(reg_rdata_valid), 16'h0001);
        check(16'(reg_rdata), 16'(TAR_UNMAPPED_DATA));
        regs_check();
        i_tar_host_model.wr(8'h22, 8'h01);
        i_tar_host_model.wr(8'h23, 8'h00);
        sample(16'hf000);
        sample(16'h0100);
        repeat (3) @(negedge clk);
        check(16'(high_flag), 16'h0000);
        sample(16'h0101);
        repeat (2) @(negedge clk);
        check(16'(high_flag), 16'h0001);
        clear_flags();
        i_tar_host_model.wr(8'h24, 8'h00);
        i_tar_host_model.wr(8'h25, 8'h00);
        for (int c = 0; c < 4; c++) begin
            sel = 2'(c);
            sample(16'h0000);
            repeat (c) sample({1'b1, 15'($random(seed))});
            repeat (3) @(negedge clk);
            check(16'(low_flag), 16'h0000);
            sample({1'b1, 15'($random(seed))});
            repeat (3) @(negedge clk);
            check(16'(low_flag), 16'h0001);
            clear_flags();
        end
        d = 8'($random(seed));
        i_tar_host_model.rdwr(8'h23, d);
        check(16'(reg_rdata), 16'h0000);
        check(high_value, {8'h01, d});
        @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        exp_reg = '{8'h7f, 8'hff, 8'h80, 8'h00, 8'h00};
        regs_check();
        check(16'({high_flag, low_flag}), 16'h0000);
        end_of_test();
    end
endmodule : testbench
